// ==== hw/qdsu_defs.svh ====
// Constants of the quad converter serial and update control block.
`ifndef QDSU_DEFS_SVH
`define QDSU_DEFS_SVH
`define QDSU_NUM_CH 4
`define QDSU_SHIFT_W 32
`define QDSU_WORD_W 24
`define QDSU_CODE_W 16
`define QDSU_CMD_MSB 23
`define QDSU_CMD_LSB 20
`define QDSU_ADDR_MSB 19
`define QDSU_ADDR_LSB 16
`define QDSU_DATA_MSB 15
`define QDSU_DATA_LSB 0
`define QDSU_CNT_W 6
`define QDSU_CMD_WR_N 4'h0
`define QDSU_CMD_WR_ALL 4'h8
`define QDSU_CMD_SPAN_N 4'h6
`define QDSU_CMD_SPAN_ALL 4'hE
`define QDSU_CMD_UPD_N 4'h1
`define QDSU_CMD_UPD_ALL 4'h9
`define QDSU_CMD_WR_UPD_N 4'h3
`define QDSU_CMD_WR_N_UPD_ALL 4'h2
`define QDSU_CMD_WR_UPD_ALL 4'hA
`define QDSU_CMD_PD_N 4'h4
`define QDSU_CMD_PD_CHIP 4'h5
`define QDSU_CMD_MUX 4'hB
`define QDSU_CMD_TSEL 4'hC
`define QDSU_CMD_GTOG 4'hD
`define QDSU_CMD_CONFIG 4'h7
`define QDSU_CMD_NOP 4'hF
`define QDSU_MUX_EN_BIT 4
`define QDSU_ZERO_CODE 16'h0000
`define QDSU_MID_CODE 16'h8000
`endif

// ==== hw/qdsu_pkg.sv ====
// Types shared by the quad converter serial and update control block.
package qdsu_pkg;
  typedef logic [15:0] qdsu_code_type;
  typedef logic [2:0] qdsu_span_type;
  typedef struct packed {
    qdsu_code_type code_a;
    qdsu_code_type code_b;
    qdsu_span_type span_in;
    qdsu_code_type dac_code;
    qdsu_span_type dac_span;
    logic powered;
  } qdsu_chan_type;
  typedef struct packed {
    logic cmd_valid;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } qdsu_cmd_type;
endpackage

// ==== hw/qdsu_serial.sv ====
// Serial shift front end: pin sampling, edge detection, framing and echo.
`timescale 1ns/1ps
`include "qdsu_defs.svh"
module qdsu_serial (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire logic cs_sync,
  input wire logic cs_rise,
  output qdsu_pkg::qdsu_cmd_type cmd_out,
  output logic sdo_out
);
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic sck_d;
    logic [31:0] shreg;
    logic sdo;
    qdsu_pkg::qdsu_cmd_type cmd;
  } qdsu_ser_type;

  qdsu_ser_type st_r;
  qdsu_ser_type st_nxt;
  logic sck_rise;
  logic sck_fall;

  // =========================================================
  // Edge finding on the synchronised serial clock.
  assign sck_rise = st_r.sck_s[1] & ~st_r.sck_d;
  assign sck_fall = ~st_r.sck_s[1] & st_r.sck_d;

  // Shifting runs only inside a frame; the last 24 bits form the word.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_s = {st_r.sck_s[0], sck_pin};
    st_nxt.sdi_s = {st_r.sdi_s[0], sdi_pin};
    st_nxt.sck_d = st_r.sck_s[1];
    st_nxt.cmd.cmd_valid = 1'b0;
    if (!cs_sync && sck_rise) begin
      st_nxt.shreg = {st_r.shreg[30:0], st_r.sdi_s[1]};
    end
    if (!cs_sync && sck_fall) begin
      st_nxt.sdo = st_r.shreg[31];
    end
    if (cs_rise) begin
      st_nxt.cmd.cmd_valid = 1'b1;
      st_nxt.cmd.cmd = st_r.shreg[`QDSU_CMD_MSB:`QDSU_CMD_LSB];
      st_nxt.cmd.addr = st_r.shreg[`QDSU_ADDR_MSB:`QDSU_ADDR_LSB];
      st_nxt.cmd.data = st_r.shreg[`QDSU_DATA_MSB:`QDSU_DATA_LSB];
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmd_out = st_r.cmd;
  assign sdo_out = st_r.sdo;
endmodule

// ==== hw/qdsu_top.sv ====
// Top of the quad converter digital control: framing, updates, toggle, clear.
// =========================================================
`timescale 1ns/1ps
`include "qdsu_defs.svh"
module qdsu_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire logic select_load_n,
  input wire logic load_update_n,
  input wire logic toggle_strobe_pin,
  input wire logic async_clear_n,
  input wire logic span_strap_bit0,
  input wire logic span_strap_bit1,
  input wire logic span_strap_bit2,
  input wire logic reference_comp_pin,
  input wire logic overtemp_event,
  output logic sdo_out,
  output logic sdo_oe,
  output logic overtemp_flag_out,
  output logic overtemp_flag_oe,
  output logic analog_monitor_oe,
  output logic [4:0] mux_select,
  output logic reference_enable,
  output logic [3:0] channel_powered,
  output logic [63:0] dac_codes,
  output logic [11:0] dac_spans
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic cs_d;
    logic [1:0] ld_s;
    logic ld_d;
    logic [1:0] tg_s;
    logic tg_d;
    logic [1:0] clr_s;
    logic [1:0] ot_s;
    logic [1:0] sp0_s;
    logic [1:0] strap_wait;
    logic [1:0] sp1_s;
    logic [1:0] sp2_s;
    logic [1:0] rc_s;
    logic strap_done;
    logic [2:0] strap_span;
    logic ref_en;
    logic ld_pending;
    logic [3:0] tsel;
    logic gtog_b;
    logic [4:0] mux;
    logic ot_flag;
    logic sdo_oe;
    qdsu_pkg::qdsu_chan_type [3:0] ch;
  } qdsu_top_type;

  qdsu_top_type st_r;
  qdsu_top_type st_nxt;
  qdsu_pkg::qdsu_cmd_type cmd;
  logic ser_sdo;
  logic cs_sync;
  logic cs_rise;
  logic ld_fall;
  logic tg_fall;
  logic tg_rise;
  logic clr_low;
  qdsu_pkg::qdsu_code_type reset_code;

  // =========================================================
  // Synchronised pin levels and their edges; first stages feed second only.
  assign cs_sync = st_r.cs_s[1];
  assign cs_rise = st_r.cs_s[1] & ~st_r.cs_d;
  assign ld_fall = ~st_r.ld_s[1] & st_r.ld_d;
  assign tg_fall = ~st_r.tg_s[1] & st_r.tg_d;
  assign tg_rise = st_r.tg_s[1] & ~st_r.tg_d;
  assign clr_low = ~st_r.clr_s[1];
  // Odd strap codes pick mid-scale; the span table itself lives in the analog side.
  assign reset_code = st_r.strap_span[0] ? `QDSU_MID_CODE : `QDSU_ZERO_CODE;

  // The front end owns the serial clock domain crossing and hands over one
  // decoded word per frame, so this module never sees raw serial clock edges.
  qdsu_serial u_serial (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck_pin(sck_pin),
    .sdi_pin(sdi_pin),
    .cs_sync(cs_sync),
    .cs_rise(cs_rise),
    .cmd_out(cmd),
    .sdo_out(ser_sdo)
  );

  // =========================================================
  // Next-state logic: commands first, then pin updates, clear last.
  always_comb begin
    logic upd_all;
    logic [3:0] upd_mask;
    logic [3:0] hit;
    upd_all = 1'b0;
    upd_mask = 4'h0;
    hit = 4'h0;
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[0], select_load_n};
    st_nxt.cs_d = st_r.cs_s[1];
    st_nxt.ld_s = {st_r.ld_s[0], load_update_n};
    st_nxt.ld_d = st_r.ld_s[1];
    st_nxt.tg_s = {st_r.tg_s[0], toggle_strobe_pin};
    st_nxt.tg_d = st_r.tg_s[1];
    st_nxt.clr_s = {st_r.clr_s[0], async_clear_n};
    st_nxt.ot_s = {st_r.ot_s[0], overtemp_event};
    st_nxt.sp0_s = {st_r.sp0_s[0], span_strap_bit0};
    st_nxt.sp1_s = {st_r.sp1_s[0], span_strap_bit1};
    st_nxt.sp2_s = {st_r.sp2_s[0], span_strap_bit2};
    st_nxt.rc_s = {st_r.rc_s[0], reference_comp_pin};
    // Straps are caught once, on the third edge after reset release.
    // The wait shifter lets both synchroniser stages fill with pin levels first;
    // catching any earlier would latch the reset zeros instead of the straps.
    st_nxt.strap_wait = {st_r.strap_wait[0], 1'b1};
    if (!st_r.strap_done && st_r.strap_wait[1]) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.strap_span = {st_r.sp2_s[1], st_r.sp1_s[1], st_r.sp0_s[1]};
      st_nxt.ref_en = st_r.rc_s[1];
      for (int i = 0; i < `QDSU_NUM_CH; i++) begin
        st_nxt.ch[i].span_in = {st_r.sp2_s[1], st_r.sp1_s[1], st_r.sp0_s[1]};
        st_nxt.ch[i].dac_span = {st_r.sp2_s[1], st_r.sp1_s[1], st_r.sp0_s[1]};
        st_nxt.ch[i].code_a = st_r.sp0_s[1] ? `QDSU_MID_CODE : `QDSU_ZERO_CODE;
        st_nxt.ch[i].code_b = st_r.sp0_s[1] ? `QDSU_MID_CODE : `QDSU_ZERO_CODE;
        st_nxt.ch[i].dac_code = st_r.sp0_s[1] ? `QDSU_MID_CODE : `QDSU_ZERO_CODE;
      end
    end
    // Serial output drives only inside a frame.
    // The line floats outside frames, so a pull resistor must set its idle level.
    st_nxt.sdo_oe = ~cs_sync;
    // Flag is set by the event; release on select rising unless still hot.
    // Set wins over release, so a die that stays hot keeps the flag asserted
    // however often the host closes frames.
    if (st_r.ot_s[1]) begin
      st_nxt.ot_flag = 1'b1;
    end else if (cs_rise) begin
      st_nxt.ot_flag = 1'b0;
    end
    // Load pin fall while framed is remembered until the frame closes.
    // Updating mid-frame would race the command still being shifted in,
    // so the pending bit carries the request past the select rising edge.
    if (ld_fall && !cs_sync) begin
      st_nxt.ld_pending = 1'b1;
    end
    if ((ld_fall && cs_sync) || (st_r.ld_pending && cs_sync)) begin
      upd_all = 1'b1;
      st_nxt.ld_pending = 1'b0;
    end
    // Channel address decode for single-channel commands.
    // Addresses above three match no channel, so such commands do nothing, except write-and-update-all, which still updates every channel.
    // Decoding the full field keeps stray pad bits from aliasing onto a channel.
    for (int i = 0; i < `QDSU_NUM_CH; i++) begin
      hit[i] = (cmd.addr == 4'(i));
    end
    if (cmd.cmd_valid) begin
      case (cmd.cmd)
        // Code writes land in the primary input register only.
        // The output follows only when an update is part of the same command.
        `QDSU_CMD_WR_N, `QDSU_CMD_WR_UPD_N, `QDSU_CMD_WR_N_UPD_ALL: begin
          for (int i = 0; i < `QDSU_NUM_CH; i++) begin
            if (hit[i]) st_nxt.ch[i].code_a = cmd.data;
          end
          if (cmd.cmd == `QDSU_CMD_WR_UPD_N) upd_mask = hit;
          if (cmd.cmd == `QDSU_CMD_WR_N_UPD_ALL) upd_all = 1'b1;
        end
        `QDSU_CMD_WR_ALL, `QDSU_CMD_WR_UPD_ALL: begin
          for (int i = 0; i < `QDSU_NUM_CH; i++) st_nxt.ch[i].code_a = cmd.data;
          if (cmd.cmd == `QDSU_CMD_WR_UPD_ALL) upd_all = 1'b1;
        end
        // Span writes are buffered like codes and reach the output on update.
        // Only the low three data bits carry a span; the rest are ignored.
        `QDSU_CMD_SPAN_N: begin
          for (int i = 0; i < `QDSU_NUM_CH; i++) begin
            if (hit[i]) st_nxt.ch[i].span_in = cmd.data[2:0];
          end
        end
        `QDSU_CMD_SPAN_ALL: begin
          for (int i = 0; i < `QDSU_NUM_CH; i++) st_nxt.ch[i].span_in = cmd.data[2:0];
        end
        // Plain updates copy whatever the input registers hold.
        // The copy itself happens in the shared update loop below.
        `QDSU_CMD_UPD_N: begin
          upd_mask = hit;
        end
        `QDSU_CMD_UPD_ALL: begin
          upd_all = 1'b1;
        end
        // Power-down is refused while the load pin is low.
        // The synchronised level is used so a glitch cannot sneak one through.
        `QDSU_CMD_PD_N: begin
          for (int i = 0; i < `QDSU_NUM_CH; i++) begin
            if (hit[i] && st_r.ld_s[1]) st_nxt.ch[i].powered = 1'b0;
          end
        end
        `QDSU_CMD_PD_CHIP: begin
          if (st_r.ld_s[1]) begin
            for (int i = 0; i < `QDSU_NUM_CH; i++) st_nxt.ch[i].powered = 1'b0;
            st_nxt.mux = 5'h00;
          end
        end
        // The mux code carries its own enable in bit four.
        // A zero code therefore also floats the monitor output.
        `QDSU_CMD_MUX: begin
          st_nxt.mux = cmd.data[4:0];
        end
        // One select bit per channel decides who follows toggle events.
        // Clear returns every select bit to zero.
        `QDSU_CMD_TSEL: begin
          st_nxt.tsel = cmd.data[3:0];
        end
        // The software toggle picks primary or alternate for selected channels.
        // It acts at once, like a pin edge, without a separate update.
        `QDSU_CMD_GTOG: begin
          st_nxt.gtog_b = cmd.data[0];
          for (int i = 0; i < `QDSU_NUM_CH; i++) begin
            if (st_r.tsel[i]) begin
              st_nxt.ch[i].dac_code = cmd.data[0] ? st_r.ch[i].code_b : st_r.ch[i].code_a;
            end
          end
        end
        // Configuration and no-operation codes change nothing in this block.
        // Every other code has its own branch above, so a corrupt frame still acts as some command.
        default: begin
        end
      endcase
    end
    // No serial command writes the alternate register; it only ever holds the
    // power-on or clear code, which limits pin toggling to that value.
    // Updates copy input registers and power the channel.
    // Copies read the next input values, so a write with update lands at once.
    for (int i = 0; i < `QDSU_NUM_CH; i++) begin
      if (upd_all || upd_mask[i]) begin
        st_nxt.ch[i].dac_code = st_nxt.ch[i].code_a;
        st_nxt.ch[i].dac_span = st_nxt.ch[i].span_in;
        st_nxt.ch[i].powered = 1'b1;
      end
      // A held-low load pin keeps every channel powered on every cycle,
      // which is what makes software power-down ineffective meanwhile.
      if (!st_r.ld_s[1]) begin
        st_nxt.ch[i].powered = 1'b1;
      end
      // Toggle edges come after commands and updates so they win over a command in the same cycle.
      // Unselected channels never see either edge.
      if (st_r.tsel[i] && tg_fall) begin
        st_nxt.ch[i].dac_code = st_r.ch[i].code_a;
        st_nxt.ch[i].powered = 1'b1;
      end
      if (st_r.tsel[i] && tg_rise) begin
        st_nxt.ch[i].dac_code = st_r.ch[i].code_b;
        st_nxt.ch[i].powered = 1'b1;
      end
    end
    // Clear is a level: while low, codes, spans, toggle selects, mux and pending load are held at strap defaults.
    // It is applied last so that none of those can escape it in any cycle; power state and the flag are left alone.
    if (clr_low) begin
      st_nxt.tsel = 4'h0;
      st_nxt.gtog_b = 1'b0;
      st_nxt.mux = 5'h00;
      st_nxt.ld_pending = 1'b0;
      for (int i = 0; i < `QDSU_NUM_CH; i++) begin
        st_nxt.ch[i].code_a = reset_code;
        st_nxt.ch[i].code_b = reset_code;
        st_nxt.ch[i].dac_code = reset_code;
        st_nxt.ch[i].span_in = st_r.strap_span;
        st_nxt.ch[i].dac_span = st_r.strap_span;
      end
    end
  end

  // State register; straps are not read here because reset takes constants.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      // Active-low pins restart at their idle high level, so no false edge follows.
      st_r.cs_s <= 2'b11;
      st_r.cs_d <= 1'b1;
      st_r.ld_s <= 2'b11;
      st_r.ld_d <= 1'b1;
      st_r.clr_s <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================
  // Outputs, all straight from state flip-flops except the flag pin, which is tied low.
  assign sdo_out = ser_sdo;
  assign sdo_oe = st_r.sdo_oe;
  // The flag pin is open drain: it only ever pulls low, and the enable says when.
  // The board pull-up supplies the released high level.
  assign overtemp_flag_out = 1'b0;
  assign overtemp_flag_oe = st_r.ot_flag;
  assign analog_monitor_oe = st_r.mux[`QDSU_MUX_EN_BIT];
  assign mux_select = st_r.mux;
  assign reference_enable = st_r.ref_en;
  generate
    for (genvar g = 0; g < `QDSU_NUM_CH; g++) begin : g_ch
      assign channel_powered[g] = st_r.ch[g].powered;
      assign dac_codes[16*g +: 16] = st_r.ch[g].dac_code;
      assign dac_spans[3*g +: 3] = st_r.ch[g].dac_span;
    end
  endgenerate
endmodule

// ==== tb/qdsu_host_model.sv ====
// Host serial master model driving the device's serial pins.
`timescale 1ns/1ps
module qdsu_host_model (
  output logic sck,
  output logic sdi,
  output logic cs_n,
  input wire logic sdo_line
);
  logic [31:0] echo;
  // The link clock rests low between frames.
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  // ==========================================================
  // Frame transfer
  // Bits go out MSB first, settled during the low phase ahead of each rising edge.
  // Echo is read late in each high phase, after the falling-edge launch has landed.
  task automatic frame(input int n, input logic [31:0] w);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #100 sck = 1'b1;
      #95 echo = {echo[30:0], sdo_line};
      #5 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    sdi = ~sdi; // A stale data line must not pass for a held value.
  endtask
endmodule

// ==== tb/qdsu_top_sva.sv ====
// Concurrent checks on the ports of the quad converter control top.
`timescale 1ns/1ps
module qdsu_top_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic select_load_n,
  input wire logic load_update_n,
  input wire logic toggle_strobe_pin,
  input wire logic async_clear_n,
  input wire logic span_strap_bit0,
  input wire logic overtemp_event,
  input wire logic sdo_oe,
  input wire logic overtemp_flag_out,
  input wire logic overtemp_flag_oe,
  input wire logic analog_monitor_oe,
  input wire logic [4:0] mux_select,
  input wire logic [3:0] channel_powered,
  input wire logic [63:0] dac_codes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Cycles since the select pin last rose, saturating so old edges never qualify.
  logic [3:0] since_rise_r;
  logic sel_d_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rise_r <= 4'hF;
      sel_d_r <= 1'b1;
    end else begin
      sel_d_r <= select_load_n;
      if (select_load_n && !sel_d_r) since_rise_r <= 4'h0;
      else if (since_rise_r != 4'hF) since_rise_r <= since_rise_r + 4'h1;
    end
  end
  chk_sdo_float: assert property (select_load_n [*5] |-> !sdo_oe)
    else $error("serial output driven while deselected");
  chk_sdo_enable: assert property (!select_load_n [*5] |-> sdo_oe)
    else $error("serial output idle inside a frame");
  chk_ot_set: assert property (overtemp_event [*5] |-> overtemp_flag_oe && !overtemp_flag_out)
    else $error("overtemperature flag not pulled low");
  chk_ot_release: assert property ($fell(overtemp_flag_oe) |-> since_rise_r <= 4'h8)
    else $error("overtemperature flag released without select rising");
  chk_mux_float: assert property (!async_clear_n [*5] |->
    !analog_monitor_oe && mux_select == 5'h00)
    else $error("monitor output driven after clear disabled the mux");
  chk_clear_code: assert property (!async_clear_n [*5] |->
    dac_codes == {4{span_strap_bit0 ? 16'h8000 : 16'h0000}})
    else $error("clear did not restore reset codes");
  chk_load_power: assert property ((!load_update_n && async_clear_n) [*5] |->
    channel_powered == 4'hF)
    else $error("load pin low left a channel powered down");
  chk_frame_quiet: assert property ((!select_load_n && load_update_n && async_clear_n &&
    $stable(toggle_strobe_pin)) [*8] |-> $stable(dac_codes))
    else $error("converter code changed inside a frame");
endmodule
bind qdsu_top qdsu_top_sva u_qdsu_top_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .select_load_n(select_load_n),
  .load_update_n(load_update_n), .toggle_strobe_pin(toggle_strobe_pin),
  .async_clear_n(async_clear_n), .span_strap_bit0(span_strap_bit0),
  .overtemp_event(overtemp_event), .sdo_oe(sdo_oe), .overtemp_flag_out(overtemp_flag_out),
  .overtemp_flag_oe(overtemp_flag_oe), .analog_monitor_oe(analog_monitor_oe),
  .mux_select(mux_select), .channel_powered(channel_powered), .dac_codes(dac_codes)
);

// ==== tb/qdsu_top_tb.sv ====
// Self-checking bench of the quad converter serial and update control.
`timescale 1ns/1ps
module qdsu_top_tb;
  logic sys_clk, rst_n, sck, sdi, cs_n, ld_n, tog, clr_n, ot_ev, sdo_line;
  logic sdo_out, sdo_oe, ot_out, ot_oe, mon_oe, ref_en;
  logic sp0, refc;
  logic [4:0] mux_sel;
  logic [3:0] pwr;
  logic [63:0] codes;
  logic [11:0] spans;
  int bad_count = 0;
  int check_count = 0;
  // The serial output has a pull-up on the board.
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;
  qdsu_host_model u_qdsu_host_model (.sck(sck), .sdi(sdi), .cs_n(cs_n), .sdo_line(sdo_line));
  qdsu_top u_qdsu_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck_pin(sck), .sdi_pin(sdi), .select_load_n(cs_n),
    .load_update_n(ld_n), .toggle_strobe_pin(tog), .async_clear_n(clr_n),
    .span_strap_bit0(sp0), .span_strap_bit1(1'b0), .span_strap_bit2(1'b0),
    .reference_comp_pin(refc), .overtemp_event(ot_ev), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .overtemp_flag_out(ot_out), .overtemp_flag_oe(ot_oe), .analog_monitor_oe(mon_oe),
    .mux_select(mux_sel), .reference_enable(ref_en), .channel_powered(pwr),
    .dac_codes(codes), .dac_spans(spans)
  );
  // ==========================================================
  // Clock and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Commands take effect a few clocks after select rises, so eight are allowed.
  task automatic send(input int n, input logic [31:0] w);
    cyc(1);
    u_qdsu_host_model.frame(n, w);
    cyc(8);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ld_n = 1'b1;
    tog = 1'b0;
    clr_n = 1'b1;
    ot_ev = 1'b0;
    sp0 = 1'b1;
    refc = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(8);
    chk(codes, {4{16'h8000}});
    chk(ref_en, 1'b0);
    chk(spans, 12'h249);
    send(24, {8'h00, 4'h0, 4'h0, 16'h1234});
    chk(codes[15:0], 16'h8000);
    send(32, {8'hFF, 4'h1, 4'h0, 16'h0000});
    chk(codes[15:0], 16'h1234);
    send(32, 32'hC3F05AA5);
    send(32, 32'h00F00000);
    chk(u_qdsu_host_model.echo, 32'hC3F05AA5);
    chk({sdo_oe, sdo_line}, 2'b01);
    send(24, {8'h00, 4'h0, 4'h1, 16'h4321});
    ld_n = 1'b0;
    cyc(4);
    ld_n = 1'b1;
    cyc(6);
    chk(codes[31:16], 16'h4321);
    send(24, {8'h00, 4'h0, 4'h2, 16'h0BCD});
    fork
      send(24, 32'h00F00000);
      begin
        cyc(40);
        ld_n = 1'b0;
        cyc(4);
        ld_n = 1'b1;
        cyc(20);
        chk(codes[47:32], 16'h8000);
      end
    join
    chk(codes[47:32], 16'h0BCD);
    ld_n = 1'b0;
    send(24, {8'h00, 4'h4, 4'h3, 16'h0000});
    chk(pwr, 4'hF);
    ld_n = 1'b1;
    send(24, {8'h00, 4'h4, 4'h3, 16'h0000});
    chk(pwr, 4'h7);
    send(24, {8'h00, 4'h1, 4'h3, 16'h0000});
    chk(pwr, 4'hF);
    send(24, {8'h00, 4'hC, 4'h0, 16'h0002});
    tog = 1'b1;
    cyc(48);
    chk(codes[31:0], {16'h8000, 16'h1234});
    tog = 1'b0;
    cyc(48);
    chk(codes[31:0], {16'h4321, 16'h1234});
    clr_n = 1'b0;
    cyc(6);
    chk(codes, {4{16'h8000}});
    clr_n = 1'b1;
    send(24, {8'h00, 4'h3, 4'h1, 16'h4444});
    tog = 1'b1;
    cyc(48);
    chk(codes[31:16], 16'h4444);
    ot_ev = 1'b1;
    cyc(8);
    chk({ot_oe, ot_out}, 2'b10);
    ot_ev = 1'b0;
    cyc(20);
    chk(ot_oe, 1'b1);
    send(24, 32'h00F00000);
    chk(ot_oe, 1'b0);
    send(24, {8'h00, 4'hB, 4'h0, 16'h0010});
    chk({mon_oe, mux_sel[4]}, 2'b11);
    send(24, {8'h00, 4'hB, 4'h0, 16'h0000});
    chk(mon_oe, 1'b0);
    // A second reset with other straps: zero code, zero span, reference on.
    sp0 = 1'b0;
    refc = 1'b1;
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(8);
    chk(codes, 64'h0);
    chk(spans, 12'h000);
    chk(ref_en, 1'b1);
    results();
  end
endmodule
